// ===== inc/usm_pkg.sv
/*
  Shared constants for the master SPI mode of the serial unit:
  mode codes, frame size, divisor layout and reset values.
  Assumes a single 40 MHz core clock domain.
*/
package usm_pkg;

  // ****************************************************
  // Clock
  // ****************************************************
  localparam int CLK_PERIOD_NS = 25;

  // ****************************************************
  // Mode select and frame format
  // ****************************************************
  localparam logic [1:0] MODE_MASTER_SPI_MODE = 2'h3;
  localparam int FRAME_BITS = 8;
  localparam int DIV_W = 12;
  localparam int DIV_LOW_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int RX_DEPTH = 2;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_BITCNT = 3'h0;
  localparam logic [1:0] RST_RXCNT = 2'h0;
  localparam logic RST_TXD = 1'b1;
  localparam logic RST_XCK = 1'b0;

  // Transfer controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } usm_fsm_t;

endpackage

// ===== rtl/usm_sync2.sv
/*
  Two-flop synchroniser for one pin level.
  Assumes the input is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module usm_sync2 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic pinIn,
  output logic pinSync
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
    end
  end

  assign pinSync = sync_ff;

endmodule

// ===== rtl/usm_baud_gen.sv
/*
  Half-bit tick generator for the transfer clock.
  Assumes divisor is stable while run is high.
*/
`timescale 1ns/1ps
module usm_baud_gen #(
  parameter int DIV_W = usm_pkg::DIV_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  // Tick, one per divisor+1 clocks
  output logic tick
);

  logic [DIV_W-1:0] cnt_ff;

  // Elaboration check: a zero-width counter cannot count
  if (DIV_W < 1)
  begin
    $error("usm_baud_gen: DIV_W must be at least 1");
  end

  // Held at zero while stopped so the first half period is full
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else if (!run || tick)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + 1'b1;
  end

  assign tick = run && (cnt_ff == divisor);

endmodule

// ===== rtl/usm_spi_master.sv
/*
  Master SPI transfer control for the serial unit: double-buffered
  8-bit frames, four clock modes, either bit order, two-deep receive
  buffer. Control bits are plain ports on core_clk; rxdIn is a pin.
  Assumes software keeps the clock pin an output and leaves mode,
  phase and order alone while a frame is shifting.
*/
`timescale 1ns/1ps
module usm_spi_master #(
  parameter int DIV_W = usm_pkg::DIV_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Mode and frame format
  input wire logic [1:0] operatingModeSelect,
  input wire logic clockPolaritySelect,
  input wire logic clockPhaseSelect,
  input wire logic bitOrderSelect,
  input wire logic transmitterEnable,
  input wire logic receiverEnable,
  // Baud divisor bytes
  input wire logic [DIV_W-usm_pkg::DIV_LOW_W-1:0] baudDivisorHigh,
  input wire logic [usm_pkg::DIV_LOW_W-1:0] baudDivisorLow,
  // Data register access
  input wire logic dataWrite,
  input wire logic [7:0] dataWriteValue,
  input wire logic dataRead,
  input wire logic txCompleteClear,
  // Status
  output logic [7:0] dataReadValue,
  output logic masterSpiMode,
  output logic dataRegEmpty,
  output logic transmitCompleteFlag,
  output logic receiveCompleteFlag,
  output logic framingErrorFlag,
  output logic dataOverrunFlag,
  output logic parityErrorFlag,
  // Serial pins
  output logic transferClockPin,
  output logic txdOut,
  output logic txdOe,
  input wire logic rxdIn
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    usm_pkg::usm_fsm_t fsm;
    logic [7:0] txBuf;
    logic bufValid;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [2:0] bitCnt;
    logic phaseHi;
    logic xck;
    logic txd;
    logic txdEn;
    logic txc;
    logic master_spi_mode;
    logic udre;
    logic [1:0] rxCnt;
    logic [1:0][7:0] rxFifo;
    logic rxc;
  } usm_state_t;

  usm_state_t st_ff;
  usm_state_t nxt_st;

  logic rxdSync;
  logic baudTick;
  logic modeOn;
  logic runOk;
  logic leadEv;
  logic trailEv;
  logic sampleEv;
  logic setupEv;
  logic frameDone;
  logic rxPush;
  logic [DIV_W-1:0] divisor;
  logic [7:0] rxNew;

  // Elaboration check: the high byte needs at least one bit
  if (DIV_W <= usm_pkg::DIV_LOW_W || DIV_W > 16)
  begin
    $error("usm_spi_master: DIV_W must be 9 to 16");
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  // Bit leaving first, per the shared order bit
  function automatic logic outBit(input logic [7:0] d, input logic msb);
    outBit = msb ? d[7] : d[0];
  endfunction

  function automatic logic [7:0] txStep(input logic [7:0] d, input logic msb);
    txStep = msb ? {d[6:0], 1'b0} : {1'b0, d[7:1]};
  endfunction

  // Received bits enter opposite the leaving end
  function automatic logic [7:0] rxStep(input logic [7:0] d, input logic msb,
                                        input logic b);
    rxStep = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction

  // ****************************************************
  // Pin sync and baud generator
  // ****************************************************
  usm_sync2 u_rxd_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(rxdIn),
    .pinSync(rxdSync)
  );

  assign divisor = {baudDivisorHigh, baudDivisorLow};

  // Tick every divisor+1 clocks, two ticks a bit
  usm_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(st_ff.fsm == usm_pkg::ST_SHIFT),
    .divisor(divisor),
    .tick(baudTick)
  );

  // ****************************************************
  // Transfer control
  // ****************************************************
  // Only the shared controller runs here; no parity or recovery
  assign modeOn = (operatingModeSelect == usm_pkg::MODE_MASTER_SPI_MODE);
  assign runOk = modeOn && transmitterEnable;
  assign leadEv = (st_ff.fsm == usm_pkg::ST_SHIFT) && baudTick && !st_ff.phaseHi;
  assign trailEv = (st_ff.fsm == usm_pkg::ST_SHIFT) && baudTick && st_ff.phaseHi;
  // Phase 0 samples leading, phase 1 samples trailing
  assign sampleEv = clockPhaseSelect ? trailEv : leadEv;
  assign setupEv = clockPhaseSelect ? leadEv
                 : (trailEv && st_ff.bitCnt != usm_pkg::LAST_BIT);
  assign frameDone = trailEv && (st_ff.bitCnt == usm_pkg::LAST_BIT);
  assign rxNew = sampleEv ? rxStep(st_ff.rxShift, bitOrderSelect, rxdSync)
               : st_ff.rxShift;
  assign rxPush = frameDone && runOk && receiverEnable;

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.master_spi_mode = modeOn;
    unique case (st_ff.fsm)
      usm_pkg::ST_IDLE:
      begin
        nxt_st.xck = clockPolaritySelect;
        nxt_st.txd = 1'b1;
      end
      usm_pkg::ST_SHIFT:
      begin
        // Aborts quietly if the mode or transmitter drops
        if (!runOk)
        begin
          nxt_st.fsm = usm_pkg::ST_IDLE;
          nxt_st.xck = clockPolaritySelect;
          nxt_st.txd = 1'b1;
        end
        else
        begin
          if (leadEv)
          begin
            nxt_st.xck = !clockPolaritySelect;
            nxt_st.phaseHi = 1'b1;
          end
          if (trailEv)
          begin
            nxt_st.xck = clockPolaritySelect;
            nxt_st.phaseHi = 1'b0;
            nxt_st.bitCnt = st_ff.bitCnt + 3'h1;
          end
          nxt_st.rxShift = rxNew;
          if (setupEv)
          begin
            nxt_st.txd = outBit(st_ff.txShift, bitOrderSelect);
            nxt_st.txShift = txStep(st_ff.txShift, bitOrderSelect);
          end
          if (frameDone)
          begin
            nxt_st.fsm = usm_pkg::ST_IDLE;
            nxt_st.txd = 1'b1;
            // Done with nothing queued raises the complete flag
            if (!st_ff.bufValid)
              nxt_st.txc = 1'b1;
          end
        end
      end
    endcase
    // Load a frame from idle, or back to back at frame end
    if (runOk && st_ff.bufValid
        && (st_ff.fsm == usm_pkg::ST_IDLE || frameDone))
    begin
      nxt_st.fsm = usm_pkg::ST_SHIFT;
      nxt_st.bufValid = 1'b0;
      nxt_st.bitCnt = usm_pkg::RST_BITCNT;
      nxt_st.phaseHi = 1'b0;
      nxt_st.rxShift = usm_pkg::RST_BYTE;
      nxt_st.txShift = st_ff.txBuf;
      // Phase 0 needs the first bit before the leading edge
      if (!clockPhaseSelect)
      begin
        nxt_st.txd = outBit(st_ff.txBuf, bitOrderSelect);
        nxt_st.txShift = txStep(st_ff.txBuf, bitOrderSelect);
      end
    end
    // Data write fills the transmit buffer when it is free and runOk holds (master SPI mode, transmitter on)
    if (dataWrite && runOk && !nxt_st.bufValid)
    begin
      nxt_st.txBuf = dataWriteValue;
      nxt_st.bufValid = 1'b1;
    end
    if (!transmitterEnable)
      nxt_st.bufValid = 1'b0;
    nxt_st.txdEn = transmitterEnable && modeOn;
    // Clear by write-one; a same-cycle completion wins
    if (txCompleteClear && !(frameDone && !st_ff.bufValid && runOk))
      nxt_st.txc = 1'b0;
    // Receive buffer: pop, then push; a full buffer drops newcomers
    if (dataRead && st_ff.rxCnt != usm_pkg::RST_RXCNT)
    begin
      nxt_st.rxFifo[0] = st_ff.rxFifo[1];
      nxt_st.rxCnt = st_ff.rxCnt - 2'h1;
    end
    if (rxPush && nxt_st.rxCnt < 2'(usm_pkg::RX_DEPTH))
    begin
      nxt_st.rxFifo[nxt_st.rxCnt[0]] = rxNew;
      nxt_st.rxCnt = nxt_st.rxCnt + 2'h1;
    end
    if (!receiverEnable)
      nxt_st.rxCnt = usm_pkg::RST_RXCNT;
    nxt_st.rxc = (nxt_st.rxCnt != usm_pkg::RST_RXCNT);
    nxt_st.udre = !nxt_st.bufValid;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.fsm <= usm_pkg::ST_IDLE;
      st_ff.txd <= usm_pkg::RST_TXD;
      st_ff.xck <= usm_pkg::RST_XCK;
      st_ff.udre <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign transferClockPin = st_ff.xck;
  assign txdOut = st_ff.txd;
  assign txdOe = st_ff.txdEn;
  assign dataReadValue = st_ff.rxFifo[0];
  assign masterSpiMode = st_ff.master_spi_mode;
  assign dataRegEmpty = st_ff.udre;
  assign transmitCompleteFlag = st_ff.txc;
  assign receiveCompleteFlag = st_ff.rxc;
  // No error sources exist in this mode
  assign framingErrorFlag = 1'b0;
  assign dataOverrunFlag = 1'b0;
  assign parityErrorFlag = 1'b0;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence lastTrail;
    frameDone && runOk;
  endsequence

  mode_gate_a: assert property (!modeOn |=> st_ff.fsm == usm_pkg::ST_IDLE)
    else $error("shifting outside master SPI mode");

  // First edge after reset still shows the reset level, so skip it
  idle_clk_a: assert property ((st_ff.fsm == usm_pkg::ST_IDLE)
    && $past(st_ff.fsm == usm_pkg::ST_IDLE) && $past(rst_n)
    |-> transferClockPin == $past(clockPolaritySelect))
    else $error("idle clock not at polarity level");

  idle_txd_a: assert property ((st_ff.fsm == usm_pkg::ST_IDLE)
    && $past(st_ff.fsm == usm_pkg::ST_IDLE) |-> txdOut)
    else $error("data line not high while idle");

  edge_tick_a: assert property ((st_ff.fsm == usm_pkg::ST_SHIFT) && baudTick
    && runOk |=> transferClockPin != $past(transferClockPin))
    else $error("transfer clock missed an edge on tick");

  fast_rate_a: assert property ((st_ff.fsm == usm_pkg::ST_SHIFT) && runOk
    && divisor == '0 && $stable(divisor) |-> baudTick)
    else $error("divisor zero not at half clock");

  txc_set_a: assert property (lastTrail and !st_ff.bufValid |=> transmitCompleteFlag)
    else $error("complete flag not set at frame end");

  queue_next_a: assert property (lastTrail and st_ff.bufValid && !st_ff.txc
    |=> st_ff.fsm == usm_pkg::ST_SHIFT && !transmitCompleteFlag)
    else $error("queued frame did not follow at once");

  ovf_keep_a: assert property (rxPush && !dataRead && receiverEnable
    && st_ff.rxCnt == 2'h2 |=> $stable(dataReadValue) && st_ff.rxCnt == 2'h2)
    else $error("overflow disturbed buffered bytes");

  buf_fill_a: assert property (dataWrite && runOk && st_ff.udre && !frameDone
    |=> !dataRegEmpty)
    else $error("write did not fill transmit buffer");

  err_zero_a: assert property (!framingErrorFlag && !dataOverrunFlag && !parityErrorFlag)
    else $error("error flag raised in SPI mode");

endmodule

// ===== test/usm_slave_model.sv
/*
  Behavioural SPI slave facing the serial pins of the master.
  Assumes a three-wire bus that is always selected; the bench holds
  clr high while it changes the frame format.
*/
`timescale 1ns/1ps
module usm_slave_model (
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // Format and reply
  input wire logic cpol,
  input wire logic cpha,
  input wire logic msbFirst,
  input wire logic clr,
  input wire logic [7:0] reply,
  output logic [7:0] got,
  output int frames
);
  logic lastClk;
  int bitNo;

  // ****
  // Bit position for the chosen order
  // ****
  function automatic int pos(input int i);
    return msbFirst ? 7 - i : i;
  endfunction

  initial
  begin
    bitNo = 0;
    frames = 0;
    got = 8'h00;
    lastClk = 1'b0;
    miso = 1'b1;
  end

  // Clock only ever comes from the master, never from here
  always @(sclk or clr)
  begin
    if (clr)
    begin
      bitNo = 0;
      // Phase 1 has no valid bit yet, so show its inverse
      miso = cpha ? ~reply[pos(0)] : reply[pos(0)];
    end
    else if ((sclk === 1'b0 || sclk === 1'b1) && sclk !== lastClk)
    begin
      if ((sclk !== cpol) ^ cpha)
      begin
        got[pos(bitNo)] = mosi;
        bitNo++;
        if (bitNo == 8)
        begin
          bitNo = 0;
          frames++;
        end
      end
      else
        miso = reply[pos(bitNo)];
    end
    lastClk = sclk;
  end
endmodule

// ===== test/usm_spi_master_tb.sv
/*
  Self-checking bench for the master SPI transfer control.
  Assumes the slave model on the pins and a 40 MHz core clock.
*/
`timescale 1ns/1ps
module usm_spi_master_tb;
  logic core_clk, rst_n, cpol, cpha, msbF, txEn, rxEn, dWr, dRd, txcClr, clr;
  logic [1:0] opMode;
  logic [3:0] divHi;
  logic [7:0] divLo, dWrVal, reply, dRdVal, slvGot;
  logic spiMode, drEmpty, txc, rxc, fe, data_overrun_flag, pe, sclk, txd, txdOe, rxd;
  int slvFrames, mismatches, numChecks, cycles;

  usm_spi_master DUT (.core_clk(core_clk), .rst_n(rst_n), .operatingModeSelect(opMode),
    .clockPolaritySelect(cpol), .clockPhaseSelect(cpha), .bitOrderSelect(msbF),
    .transmitterEnable(txEn), .receiverEnable(rxEn), .baudDivisorHigh(divHi),
    .baudDivisorLow(divLo), .dataWrite(dWr), .dataWriteValue(dWrVal), .dataRead(dRd),
    .txCompleteClear(txcClr), .dataReadValue(dRdVal), .masterSpiMode(spiMode),
    .dataRegEmpty(drEmpty), .transmitCompleteFlag(txc), .receiveCompleteFlag(rxc),
    .framingErrorFlag(fe), .dataOverrunFlag(data_overrun_flag), .parityErrorFlag(pe),
    .transferClockPin(sclk), .txdOut(txd), .txdOe(txdOe), .rxdIn(rxd));

  usm_slave_model SLV (.sclk(sclk), .mosi(txd), .miso(rxd), .cpol(cpol), .cpha(cpha),
    .msbFirst(msbF), .clr(clr), .reply(reply), .got(slvGot), .frames(slvFrames));

  // ****
  // Clock and hang guard
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Longest test is one slow frame of about 4k cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      printVerdict;
    end
  end

  // ****
  // Compare and bus helpers
  // ****
  task automatic cmpB(input logic [7:0] g, input logic [7:0] e);
    numChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmpN(input int g, input int e);
    numChecks++;
    if (g != e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] v);
    @(negedge core_clk);
    dWr = 1'b1;
    dWrVal = v;
    @(negedge core_clk);
    dWr = 1'b0;
  endtask

  // Head of the receive buffer, then pop it
  task automatic rd(input logic [7:0] e);
    cmpB(dRdVal, e);
    @(negedge core_clk);
    dRd = 1'b1;
    @(negedge core_clk);
    dRd = 1'b0;
    cyc(1);
  endtask

  task automatic waitHi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    cmpN(n, n < 5000 ? n : -1);
  endtask

  // Format is only changed with the slave held idle; new format first,
  // so the slave's clear already sees it
  task automatic fmt(input logic [2:0] m, input logic [7:0] rep);
    @(negedge core_clk);
    {cpol, cpha, msbF} = m;
    reply = rep;
    clr = 1'b1;
    txcClr = 1'b1;
    cyc(4);
    txcClr = 1'b0;
    clr = 1'b0;
  endtask

  // Core cycles spent over the given number of clock-pin edges
  task automatic edges(input int k, output int n);
    logic last;
    n = 0;
    repeat (k)
    begin
      last = sclk;
      while (sclk === last && n < 9000)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic tReset;
    cmpB({spiMode, drEmpty, txc, rxc, fe | data_overrun_flag | pe, txd, txdOe, sclk}, 8'h44);
    wr(8'hA5);
    cyc(20);
    cmpB({5'h0, sclk, drEmpty, txc}, 8'h02);
    opMode = 2'h3;
    cyc(3);
    cmpB({6'h0, spiMode, txdOe}, 8'h03);
    $display("test reset done");
  endtask

  task automatic tModes;
    logic [7:0] v;
    for (int m = 0; m < 8; m++)
    begin
      v = 8'hA6 ^ 8'(m);
      fmt(3'(m), ~v);
      wr(v);
      waitHi(txc);
      cmpB(slvGot, v);
      cmpB({5'h0, sclk, txd, fe | data_overrun_flag | pe}, {5'h0, cpol, 1'b1, 1'b0});
      rd(~v);
      cmpB({7'h0, rxc}, 8'h00);
    end
    $display("test modes done");
  endtask

  task automatic rate(input logic [3:0] h, input logic [7:0] l, input int e);
    int n;
    divHi = h;
    divLo = l;
    fmt(3'h1, 8'h00);
    wr(8'h5A);
    edges(1, n);
    edges(1, n);
    cmpN(n, e);
    waitHi(txc);
    rd(8'h00);
  endtask

  task automatic tRate;
    rate(4'h0, 8'h05, 6);
    rate(4'h1, 8'h00, 257);
    rate(4'h0, 8'h00, 1);
    divLo = 8'h03;
    $display("test rate done");
  endtask

  task automatic tQueue;
    int a, b, f;
    fmt(3'h1, 8'h0F);
    f = slvFrames;
    wr(8'hC3);
    wr(8'h1E);
    cmpB({7'h0, drEmpty}, 8'h00);
    edges(1, a);
    edges(15, a);
    cmpB({7'h0, txc}, 8'h00);
    edges(16, b);
    cmpN(a + b, 31 * 4);
    waitHi(txc);
    cmpN(slvFrames - f, 2);
    cmpB({7'h0, drEmpty}, 8'h01);
    cmpB(slvGot, 8'h1E);
    rd(8'h0F);
    rd(8'h0F);
    $display("test queue done");
  endtask

  task automatic tOverflow;
    logic [7:0] rep [3] = '{8'hA1, 8'hB2, 8'hC3};
    for (int i = 0; i < 3; i++)
    begin
      fmt(3'h4, rep[i]);
      wr(8'h11 * 8'(i + 1));
      waitHi(txc);
    end
    rd(8'hA1);
    rd(8'hB2);
    cmpB({7'h0, rxc}, 8'h00);
    $display("test overflow done");
  endtask

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    {rst_n, cpol, cpha, msbF, dWr, dRd, txcClr, clr} = 8'h00;
    {opMode, divHi, divLo, dWrVal, reply} = 30'h0;
    // Clock pin is an output by construction before enabling
    txEn = 1'b1;
    rxEn = 1'b1;
    mismatches = 0;
    numChecks = 0;
    cycles = 0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    divLo = 8'h03;
    tReset;
    tModes;
    tRate;
    tQueue;
    tOverflow;
    printVerdict;
  end
endmodule
